// File: logic/mcsb_bank.v
`include "mcsb_defs.vh"
`default_nettype none

module mcsb_bank #(
  parameter [1:0] SILICON_REV = 2'h0,
  // arbitrary value
  parameter [3:0] FAMILY_VERSION = 4'h5
) (
  // clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // register port from serial slave
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // system status
  input wire power_good_i,
  input wire [`MCSB_FLAG_COUNT-1:0] limit_cond_i,
  input wire [7:0] status_two_i,
  input wire overtemp_pin_i,
  input wire overtemp_use_max_i,
  // fan drive
  input wire [7:0] auto_duty_i,
  input wire [7:0] max_duty_i,
  output reg [7:0] fan_duty_o,
  // control to engines
  output reg monitor_run_o,
  output reg use_programmed_limits_o,
  output reg cpu_temp_poll_enable_o,
  output reg [5:0] averaging_count_o,
  output reg lock_o
);

  // ----------------------------------------
  // configuration fields
  // ----------------------------------------
  reg monitor_run_reg;
  reg lock_reg;
  reg ready_reg;
  reg fan_boost_reg;
  reg cpu_temp_poll_enable_reg;
  reg overtemp_pin_full_fan_reg;
  reg [1:0] averaging_length_reg;
  wire [`MCSB_FLAG_COUNT-1:0] flags;
  wire secondary_events_pending;
  wire cfg_wr;
  wire flags_rd;
  wire [7:0] ident_value;
  wire [7:0] config_value;
  wire [7:0] flags_value;
  reg [7:0] rdata_next;
  reg [7:0] duty_next;
  reg [5:0] avg_next;
  wire overtemp_override;
  wire [7:0] override_duty;
  wire force_full;

  assign cfg_wr = reg_wr_i && (reg_addr_i == `MCSB_ADDR_CONFIG);
  assign flags_rd = reg_rd_i && (reg_addr_i == `MCSB_ADDR_FLAGS);

  // ----------------------------------------
  // configuration reset image
  // ----------------------------------------
  // a macro literal cannot be bit-selected, so the reset word is held here first
  localparam [7:0] CONFIG_RESET = `MCSB_CONFIG_RESET;
  localparam [0:0] RUN_RESET = CONFIG_RESET[`MCSB_CFG_RUN_BIT];
  localparam [0:0] LOCK_RESET = CONFIG_RESET[`MCSB_CFG_LOCK_BIT];
  localparam [0:0] BOOST_RESET = CONFIG_RESET[`MCSB_CFG_BOOST_BIT];
  localparam [0:0] POLL_RESET = CONFIG_RESET[`MCSB_CFG_POLL_BIT];
  localparam [0:0] OVERTEMP_RESET = CONFIG_RESET[`MCSB_CFG_OVERTEMP_BIT];
  localparam [1:0] AVG_RESET = CONFIG_RESET[`MCSB_CFG_AVG_MSB:`MCSB_CFG_AVG_LSB];

  // ----------------------------------------
  // host-writable fields
  // ----------------------------------------
  // run always writable
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      monitor_run_reg <= RUN_RESET;
    end else if (cfg_wr) begin
      monitor_run_reg <= reg_wdata_i[`MCSB_CFG_RUN_BIT];
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      fan_boost_reg <= BOOST_RESET;
    end else if (cfg_wr) begin
      fan_boost_reg <= reg_wdata_i[`MCSB_CFG_BOOST_BIT];
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cpu_temp_poll_enable_reg <= POLL_RESET;
    end else if (cfg_wr && !lock_reg) begin
      cpu_temp_poll_enable_reg <= reg_wdata_i[`MCSB_CFG_POLL_BIT];
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      overtemp_pin_full_fan_reg <= OVERTEMP_RESET;
    end else if (cfg_wr && !lock_reg) begin
      overtemp_pin_full_fan_reg <= reg_wdata_i[`MCSB_CFG_OVERTEMP_BIT];
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      averaging_length_reg <= AVG_RESET;
    end else if (cfg_wr && !lock_reg) begin
      averaging_length_reg <= reg_wdata_i[`MCSB_CFG_AVG_MSB:`MCSB_CFG_AVG_LSB];
    end
  end

  // ----------------------------------------
  // lock and ready
  // ----------------------------------------
  // the reset input stands for power-on; a soft reset that is not a power cycle must not reach here
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      lock_reg <= LOCK_RESET;
    end else if (cfg_wr && reg_wdata_i[`MCSB_CFG_LOCK_BIT]) begin
      lock_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // power-up ready
  // ----------------------------------------
  // ready is held low until power good, then stays set
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ready_reg <= 1'b0;
    end else if (power_good_i) begin
      ready_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // event flags
  // ----------------------------------------
  // read-clear with persistence
  mcsb_flag_latch #(
    .WIDTH(`MCSB_FLAG_COUNT)
  ) u_flags (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .cond_i(limit_cond_i),
    .read_clear_i(flags_rd),
    .flag_o(flags)
  );

  assign secondary_events_pending = |status_two_i;

  // ----------------------------------------
  // read values
  // ----------------------------------------
  // revision
  assign ident_value = {FAMILY_VERSION, 1'b1, 1'b1, SILICON_REV};
  assign config_value = {averaging_length_reg, overtemp_pin_full_fan_reg, cpu_temp_poll_enable_reg,
                         fan_boost_reg, ready_reg, lock_reg, monitor_run_reg};
  assign flags_value = {secondary_events_pending, flags};

  always @* begin
    rdata_next = 8'h00;
    case (reg_addr_i)
      `MCSB_ADDR_IDENT: begin
        rdata_next = ident_value;
      end
      `MCSB_ADDR_CONFIG: begin
        rdata_next = config_value;
      end
      `MCSB_ADDR_FLAGS: begin
        rdata_next = flags_value;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // fan duty and averaging
  // ----------------------------------------
  // overtemp pin override
  assign overtemp_override = overtemp_pin_full_fan_reg && overtemp_pin_i;
  assign override_duty = overtemp_use_max_i ? max_duty_i : `MCSB_DUTY_FULL;
  // stopped means full duty
  // stop and boost outrank the pin so a halted monitor never runs the fans slow
  assign force_full = fan_boost_reg || !monitor_run_reg;

  always @* begin
    duty_next = auto_duty_i;
    if (force_full) begin
      duty_next = `MCSB_DUTY_FULL;
    end else if (overtemp_override) begin
      duty_next = override_duty;
    end
  end

  always @* begin
    avg_next = `MCSB_AVG_4;
    case (averaging_length_reg)
      2'h0: begin
        avg_next = `MCSB_AVG_4;
      end
      2'h1: begin
        avg_next = `MCSB_AVG_8;
      end
      2'h2: begin
        avg_next = `MCSB_AVG_16;
      end
      default: begin
        avg_next = `MCSB_AVG_32;
      end
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // read data holds until the next read strobe
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_next;
    end
  end

  // ----------------------------------------
  // fan duty output
  // ----------------------------------------
  // full duty from reset on
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      fan_duty_o <= `MCSB_DUTY_FULL;
    end else begin
      fan_duty_o <= duty_next;
    end
  end

  // ----------------------------------------
  // control outputs to engines
  // ----------------------------------------
  // run bit to engines
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      monitor_run_o <= 1'b0;
    end else begin
      monitor_run_o <= monitor_run_reg;
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      use_programmed_limits_o <= 1'b0;
    end else begin
      use_programmed_limits_o <= monitor_run_reg;
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cpu_temp_poll_enable_o <= 1'b0;
    end else begin
      cpu_temp_poll_enable_o <= cpu_temp_poll_enable_reg;
    end
  end

  // averaging count to engine
  // the count goes out as a number, so the engines need no decode of their own
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      averaging_count_o <= `MCSB_AVG_4;
    end else begin
      averaging_count_o <= avg_next;
    end
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      lock_o <= 1'b0;
    end else begin
      lock_o <= lock_reg;
    end
  end

endmodule

`default_nettype wire

// File: logic/mcsb_defs.vh
`ifndef MCSB_DEFS_VH
`define MCSB_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MCSB_ADDR_IDENT 8'h3F
`define MCSB_ADDR_CONFIG 8'h40
`define MCSB_ADDR_FLAGS 8'h41

// ----------------------------------------
// identity field positions
// ----------------------------------------
`define MCSB_ID_REV_LSB 0
`define MCSB_ID_REV_MSB 1
`define MCSB_ID_CPU_TEMP_BIT 2
`define MCSB_ID_FOUR_WIRE_BIT 3
`define MCSB_ID_VER_LSB 4
`define MCSB_ID_VER_MSB 7

// ----------------------------------------
// configuration field positions
// ----------------------------------------
`define MCSB_CFG_RUN_BIT 0
`define MCSB_CFG_LOCK_BIT 1
`define MCSB_CFG_READY_BIT 2
`define MCSB_CFG_BOOST_BIT 3
`define MCSB_CFG_POLL_BIT 4
`define MCSB_CFG_OVERTEMP_BIT 5
`define MCSB_CFG_AVG_LSB 6
`define MCSB_CFG_AVG_MSB 7

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define MCSB_CONFIG_RESET 8'h84
`define MCSB_FLAGS_RESET 8'h00
`define MCSB_DUTY_FULL 8'hFF
`define MCSB_FLAG_COUNT 7
`define MCSB_AVG_4 6'h04
`define MCSB_AVG_8 6'h08
`define MCSB_AVG_16 6'h10
`define MCSB_AVG_32 6'h20

`endif

// File: logic/mcsb_flag_latch.v
`default_nettype none

// ----------------------------------------
// sticky limit flags, cleared on read only when condition gone
// ----------------------------------------
module mcsb_flag_latch #(
  parameter WIDTH = 7
) (
  // clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // events
  input wire [WIDTH-1:0] cond_i,
  input wire read_clear_i,
  // flags
  output reg [WIDTH-1:0] flag_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          flag_o[g] <= 1'b0;
        end else if (cond_i[g]) begin
          flag_o[g] <= 1'b1;
        end else if (read_clear_i) begin
          flag_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: tb/mcsb_chk.sv
`default_nettype none
// ----
// bank checker
// ----
module mcsb_chk #(
  parameter logic [1:0] SILICON_REV = 2'h0,
  parameter logic [3:0] FAMILY_VERSION = 4'h5
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [6:0] limit_cond_i,
  input wire logic [7:0] status_two_i,
  input wire logic [7:0] fan_duty_o,
  input wire logic monitor_run_o,
  input wire logic cpu_temp_poll_enable_o,
  input wire logic [5:0] averaging_count_o,
  input wire logic lock_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic wr_cfg = reg_wr_i && reg_addr_i == 8'h40;
  wire logic rd_flg = reg_rd_i && reg_addr_i == 8'h41;
  ident_value_a: assert property (reg_rd_i && reg_addr_i == 8'h3F |=>
    reg_rdata_o == {FAMILY_VERSION, 2'b11, SILICON_REV}) else $error("identity read wrong");
  run_write_a: assert property (wr_cfg |-> ##2 monitor_run_o == $past(reg_wdata_i[0], 2))
    else $error("run bit not taken");
  boost_full_a: assert property (wr_cfg && reg_wdata_i[3] |-> ##2 fan_duty_o == 8'hFF)
    else $error("boost not full duty");
  stop_full_a: assert property (!monitor_run_o |-> fan_duty_o == 8'hFF)
    else $error("stopped but not full duty");
  avg_poll_a: assert property (wr_cfg ##1 !lock_o |=> averaging_count_o == 6'h04 << $past(reg_wdata_i[7:6], 2)
    && cpu_temp_poll_enable_o == $past(reg_wdata_i[4], 2)) else $error("averaging or poll wrong");
  lock_hold_a: assert property (lock_o |=> lock_o && $stable(averaging_count_o)
    && $stable(cpu_temp_poll_enable_o)) else $error("locked field moved");
  pending_or_a: assert property (rd_flg |=> reg_rdata_o[7] == $past(|status_two_i))
    else $error("pending bit wrong");
  reread_flag_a: assert property (rd_flg ##1 rd_flg |=> reg_rdata_o[6:0] == $past(limit_cond_i, 2))
    else $error("flag clear wrong");
  cover property (wr_cfg && reg_wdata_i[1]);
  cover property (rd_flg ##1 rd_flg);
  cover property (lock_o && wr_cfg);
endmodule

bind mcsb_bank mcsb_chk #(.SILICON_REV(SILICON_REV), .FAMILY_VERSION(FAMILY_VERSION)) i_mcsb_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .limit_cond_i(limit_cond_i),
  .status_two_i(status_two_i), .fan_duty_o(fan_duty_o), .monitor_run_o(monitor_run_o),
  .cpu_temp_poll_enable_o(cpu_temp_poll_enable_o), .averaging_count_o(averaging_count_o), .lock_o(lock_o));
`default_nettype wire

// File: tb/mcsb_host.sv
`default_nettype none
// ----
// register host
// ----
module mcsb_host (
  input wire logic core_clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr_o, wdata_o, wr_o, rd_o} = 18'h00000;
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
    @(negedge core_clk_i);
    // released data must not keep its last value
    {wdata_o, wr_o} = {~d, 1'b0};
  endtask
  task rd2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1, input bit two);
    @(negedge core_clk_i);
    {addr_o, rd_o} = {a, 1'b1};
    @(negedge core_clk_i);
    d0 = rdata_i;
    d1 = rdata_i;
    if (two) begin
      @(negedge core_clk_i);
      d1 = rdata_i;
    end
    rd_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // arbitrary identity values
  localparam logic [3:0] FV = 4'hA;
  localparam logic [1:0] SR = 2'h2;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, power_good_i = 1'b0, overtemp_pin_i = 1'b0, overtemp_use_max_i = 1'b0;
  logic [6:0] limit_cond_i = 7'h00;
  logic [7:0] status_two_i = 8'h00, auto_duty_i = 8'h3C, max_duty_i = 8'hA0, d0, d1;
  wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, fan_duty_o;
  wire logic reg_wr_i, reg_rd_i, monitor_run_o, use_programmed_limits_o, cpu_temp_poll_enable_o, lock_o;
  wire logic [5:0] averaging_count_o;
  int errors = 0, cmp_count = 0;
  always #5 core_clk_i = ~core_clk_i;
  mcsb_bank #(.SILICON_REV(SR), .FAMILY_VERSION(FV)) i_mcsb_bank (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .power_good_i(power_good_i), .limit_cond_i(limit_cond_i),
    .status_two_i(status_two_i), .overtemp_pin_i(overtemp_pin_i), .overtemp_use_max_i(overtemp_use_max_i),
    .auto_duty_i(auto_duty_i), .max_duty_i(max_duty_i), .fan_duty_o(fan_duty_o), .monitor_run_o(monitor_run_o),
    .use_programmed_limits_o(use_programmed_limits_o), .cpu_temp_poll_enable_o(cpu_temp_poll_enable_o),
    .averaging_count_o(averaging_count_o), .lock_o(lock_o));
  mcsb_host i_mcsb_host (.core_clk_i(core_clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
    .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task rd(input logic [7:0] a);
    i_mcsb_host.rd2(a, d0, d1, 1'b0);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_mcsb_host.wr(a, d);
    // config effects reach the outputs two edges after the write
    repeat (2) @(negedge core_clk_i);
  endtask
  task t_ident();
    chk("fan_rst", 8'hFF, fan_duty_o);
    rd(8'h40);
    chk("cfg_pre", 8'h80, d0);
    power_good_i = 1'b1;
    wr(8'h3F, 8'hFF);
    rd(8'h3F);
    chk("ident", {FV, 2'b11, SR}, d0);
    rd(8'h40);
    chk("cfg_rdy", 8'h84, d0);
    rd(8'h50);
    chk("unmapped", 8'h00, d0);
  endtask
  task t_run();
    wr(8'h40, 8'h01);
    chk("run_duty", 8'h3C, fan_duty_o);
    chk("run_out", 8'h03, {6'h00, use_programmed_limits_o, monitor_run_o});
    wr(8'h40, 8'h09);
    chk("boost", 8'hFF, fan_duty_o);
    for (int c = 0; c < 4; c++) begin
      wr(8'h40, {c[1:0], 6'h11});
      chk("avg", 8'h04 << c, {2'b00, averaging_count_o});
    end
    chk("unboost", 8'h3C, fan_duty_o);
    chk("poll", 8'h01, {7'h00, cpu_temp_poll_enable_o});
  endtask
  task t_override();
    {overtemp_pin_i, overtemp_use_max_i} = 2'b11;
    wr(8'h40, 8'h21);
    chk("ovr_max", 8'hA0, fan_duty_o);
    overtemp_use_max_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk("ovr_full", 8'hFF, fan_duty_o);
    wr(8'h40, 8'h01);
    chk("ovr_off", 8'h3C, fan_duty_o);
    overtemp_pin_i = 1'b0;
  endtask
  task t_flags();
    limit_cond_i = 7'h55;
    @(negedge core_clk_i);
    limit_cond_i = 7'h01;
    i_mcsb_host.rd2(8'h41, d0, d1, 1'b1);
    chk("flags", 8'h55, d0);
    chk("reread", 8'h01, d1);
    {limit_cond_i, status_two_i} = {7'h00, 8'h10};
    rd(8'h41);
    chk("pending", 8'h81, d0);
  endtask
  task t_lock();
    wr(8'h40, 8'h13);
    wr(8'h40, 8'hE8);
    rd(8'h40);
    chk("locked", 8'h1E, d0);
    chk("stop", 8'hFF, fan_duty_o);
    chk("run_off", 8'h00, {6'h00, use_programmed_limits_o, monitor_run_o});
    chk("lock_out", 8'h01, {7'h00, lock_o});
  endtask
  task complete_run();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    @(negedge core_clk_i);
    t_ident();
    t_run();
    t_override();
    t_flags();
    t_lock();
    complete_run();
  end
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
